// *** design/qdpc_pkg.sv ***
// Shared constants, codes and register map of the quad DAC pin control block.
// Assumes one 250 MHz system clock and an APB3 register port with 12-bit addresses.
package qdpc_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int SPIKE_NS      = 50;
	// Least stable time, rounded up to whole cycles
	localparam int SPIKE_CYC     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// Serial word layout
	// ------------------------------------------------------------------
	localparam int         WORD_BITS   = 24;
	localparam int         WORD_CH_LSB = 16;
	localparam logic [3:0] BYTE_BITS   = 4'h8;
	localparam logic [1:0] LAST_BYTE   = 2'h2;
	// Upper slave address bits after reset; arbitrary value
	localparam logic [4:0] ADDR_HIGH_RST = 5'h0A;

	// ------------------------------------------------------------------
	// DAC codes
	// ------------------------------------------------------------------
	localparam logic [15:0] CODE_ZERO = 16'h0000; // [RL13]
	localparam logic [15:0] CODE_MID  = 16'h8000;
	localparam logic [15:0] CODE_FULL = 16'hFFFF; // [RL13]

	// ------------------------------------------------------------------
	// Register map and pin reset values
	// ------------------------------------------------------------------
	localparam int          APB_AW        = 12;
	localparam logic [11:0] OFS_CTRL      = 12'h000;
	localparam logic [11:0] OFS_STATUS    = 12'h004;
	localparam logic [11:0] OFS_DAC       = 12'h010;
	localparam logic [11:0] OFS_INREG     = 12'h020;
	localparam int          CTRL_LOAD_BIT = 8;
	// Bus lines idle high
	localparam logic [1:0]  BUS_RST       = 2'h3;
	// Load strobe idle high, reset pin seen active until synchronised
	localparam logic [5:0]  PIN_RST       = 6'h20;

	// Reset code picked by the reset-level strap
	function automatic logic [15:0] rst_code(input logic mid);
		return mid ? CODE_MID : CODE_ZERO;
	endfunction

endpackage

// *** design/qdpc_sync.sv ***
// Two-flop synchroniser for slow pins and straps.
// Assumes inputs change far slower than the system clock.
`timescale 1ns/1ps
module qdpc_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// Pins in, synchronised out
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} qdpc_sync_t;

	qdpc_sync_t s;
	qdpc_sync_t next_s;

	// First stage feeds only the second
	always_comb begin
		next_s    = s;
		next_s.s1 = pin;
		next_s.s2 = s.s1;
	end

	// State register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= {RST_VAL, RST_VAL};
		end else begin
			s <= next_s;
		end
	end

	assign q = s.s2;

endmodule

// *** design/qdpc_filter.sv ***
// Spike filter for the serial clock and data lines: sync, then stability count.
// Assumes pins are asynchronous to clk; a change is taken after STABLE equal samples.
`timescale 1ns/1ps
module qdpc_filter #(
	parameter int               WIDTH   = 2,
	parameter int               STABLE  = 13,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// Pins in, filtered levels out
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] q
);

	localparam int            CW   = $clog2(STABLE + 1);
	localparam logic [CW-1:0] LAST = CW'(STABLE - 1);

	typedef struct packed {
		logic [WIDTH-1:0]         s1;
		logic [WIDTH-1:0]         s2;
		logic [WIDTH-1:0]         q;
		logic [WIDTH-1:0][CW-1:0] cnt;
	} qdpc_flt_t;

	qdpc_flt_t s;
	qdpc_flt_t next_s;

	// Level must differ for STABLE cycles in a row before it is taken
	always_comb begin
		next_s    = s;
		next_s.s1 = pin;
		next_s.s2 = s.s1;
		for (int i = 0; i < WIDTH; i++) begin
			if (s.s2[i] == s.q[i]) begin
				next_s.cnt[i] = '0;
			end else if (s.cnt[i] == LAST) begin
				next_s.q[i]   = s.s2[i]; // [RL12]
				next_s.cnt[i] = '0;
			end else begin
				next_s.cnt[i] = s.cnt[i] + 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= {RST_VAL, RST_VAL, RST_VAL, {(WIDTH * CW){1'b0}}};
		end else begin
			s <= next_s;
		end
	end

	assign q = s.q;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_spike_filter: assert property ( // [RL12]
		(s.q[0] != $past(s.q[0])) |-> ($past(s.cnt[0]) == LAST && $past(s.s2[0]) == s.q[0]))
		else $error("filtered level changed before it was stable");

endmodule

// *** design/qdpc_top.sv ***
// Quad DAC pin control: two-wire slave, input and DAC registers, load strobe,
// reset pin and straps, with an APB3 port for readback and control.
// Assumes APB on SYS_CLK, all device pins asynchronous, SDA pulled up outside.
//
// How it works
// [RL1] Bits move through a 24-bit shift register
// [RL2] SDA only pulled low, otherwise released
// [RL3] Load strobe copies pending inputs to all DACs
// [RL4] Async strobe mode, sync mode, or tied low
// [RL5] Address bits 0 and 1 from straps
// [RL6] Reset pin low loads zero or midscale
// [RL7] Load strobe ignored while reset pin low
// [RL8] Initialisation completes only after reset release
// [RL9] Power-up value zero or midscale by strap
// [RL10] Gain strap sets span of all channels
// [RL11] One write word carries 24 bits
// [RL12] Spikes under 50 ns never seen as edges
// [RL13] Zero code all zeros, full all ones
// [RL14] Initial value holds until write or load
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module qdpc_top #(
	parameter int NCH = 4,
	parameter int DW  = 16
) (
	// Clock and reset
	input  wire logic                          SYS_CLK,
	input  wire logic                          RST_B,
	// APB slave
	input  wire logic                          PSEL,
	input  wire logic                          PENABLE,
	input  wire logic                          PWRITE,
	input  wire logic [qdpc_pkg::APB_AW-1:0]   PADDR,
	input  wire logic [31:0]                   PWDATA,
	output logic      [31:0]                   PRDATA,
	output logic                               PREADY,
	output logic                               PSLVERR,
	// Two-wire bus
	input  wire logic                          SCL_IN,
	input  wire logic                          SDA_IN,
	output logic                               SDA_OUT,
	output logic                               SDA_OE_N,
	// Control pins and straps
	input  wire logic                          LOAD_STROBE_N,
	input  wire logic                          DAC_RESET_N,
	input  wire logic                          RESET_LEVEL_SELECT,
	input  wire logic                          GAIN_SEL,
	input  wire logic                          ADDR_STRAP_BIT1,
	input  wire logic                          ADDR_STRAP_BIT0,
	// Converter side
	output logic      [NCH-1:0][DW-1:0]        DAC_CODE,
	output logic                               GAIN_SPAN
);

	localparam int CHW = $clog2(NCH);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef enum logic [5:0] {
		QDPC_IDLE = 6'h01,
		QDPC_ADDR = 6'h02,
		QDPC_ACK  = 6'h04,
		QDPC_RX   = 6'h08,
		QDPC_TX   = 6'h10,
		QDPC_MACK = 6'h20
	} qdpc_st_t;

	typedef struct packed {
		qdpc_st_t                   st;
		logic                       scl_q;
		logic                       sda_q;
		logic [3:0]                 bitcnt;
		logic [1:0]                 bytecnt;
		logic [7:0]                 sh;
		logic [qdpc_pkg::WORD_BITS-1:0] rxw;
		logic [qdpc_pkg::WORD_BITS-1:0] txw;
		logic                       rw;
		logic                       sda_low;
		logic                       wvalid;
		logic [NCH-1:0][DW-1:0]     dac;
		logic [NCH-1:0][DW-1:0]     inreg;
		logic [NCH-1:0]             pend;
		logic                       init_done;
		logic                       load_strobe_n_q;
		logic                       gain;
		logic [4:0]                 addr_high;
		logic [CHW-1:0]             rd_ch;
		logic                       pready;
		logic                       pslverr;
		logic [31:0]                prdata;
		logic                       sda_oe_n;
	} qdpc_state_t;

	qdpc_state_t s;
	qdpc_state_t next_s;

	logic [1:0]     bus_f;
	logic [5:0]     pin_f;
	logic           scl_f;
	logic           sda_f;
	logic           load_strobe_n_f;
	logic           rpin_f;
	logic           reset_level_select_f;
	logic           gain_f;
	logic [6:0]     slave_addr;
	logic           scl_rise;
	logic           scl_fall;
	logic           bus_start;
	logic           bus_stop;
	logic           load_strobe_n_fall;
	logic           apb_setup;
	logic           apb_wr;
	logic           soft_load;
	logic           in_dac;
	logic           in_inreg;
	logic [CHW-1:0] a_idx;
	logic [CHW-1:0] w_ch;
	logic [DW-1:0]  w_data;

	// ------------------------------------------------------------------
	// Pin conditioning
	// ------------------------------------------------------------------
	// Bus lines need the spike filter; strobe and straps only a sync
	qdpc_filter #(
		.WIDTH   (2),
		.STABLE  (qdpc_pkg::SPIKE_CYC),
		.RST_VAL (qdpc_pkg::BUS_RST)
	) u_bus_filter (
		.clk   (SYS_CLK),
		.rst_b (RST_B),
		.pin   ({SCL_IN, SDA_IN}),
		.q     (bus_f)
	);

	qdpc_sync #(
		.WIDTH   (6),
		.RST_VAL (qdpc_pkg::PIN_RST)
	) u_pin_sync (
		.clk   (SYS_CLK),
		.rst_b (RST_B),
		.pin   ({LOAD_STROBE_N, DAC_RESET_N, RESET_LEVEL_SELECT, GAIN_SEL,
		         ADDR_STRAP_BIT1, ADDR_STRAP_BIT0}),
		.q     (pin_f)
	);

	// Named levels and edges
	assign scl_f      = bus_f[1];
	assign sda_f      = bus_f[0];
	assign load_strobe_n_f     = pin_f[5];
	assign rpin_f     = pin_f[4];
	assign reset_level_select_f   = pin_f[3];
	assign gain_f     = pin_f[2];
	assign slave_addr = {s.addr_high, pin_f[1], pin_f[0]}; // [RL5]
	assign scl_rise   = !s.scl_q && scl_f;
	assign scl_fall   = s.scl_q && !scl_f;
	assign bus_start  = scl_f && s.scl_q && s.sda_q && !sda_f;
	assign bus_stop   = scl_f && s.scl_q && !s.sda_q && sda_f;
	assign load_strobe_n_fall  = s.load_strobe_n_q && !load_strobe_n_f;

	// APB decode; stride of one word per channel
	assign apb_setup = PSEL && !PENABLE;
	assign apb_wr    = PSEL && PENABLE && s.pready && PWRITE && !s.pslverr;
	assign soft_load = apb_wr && (PADDR == qdpc_pkg::OFS_CTRL) && PWDATA[qdpc_pkg::CTRL_LOAD_BIT];
	assign in_dac    = (PADDR[11:4] == qdpc_pkg::OFS_DAC[11:4]) && (PADDR[1:0] == 2'h0);
	assign in_inreg  = (PADDR[11:4] == qdpc_pkg::OFS_INREG[11:4]) && (PADDR[1:0] == 2'h0);
	assign a_idx     = PADDR[CHW+1:2];
	assign w_ch      = s.rxw[qdpc_pkg::WORD_CH_LSB +: CHW];
	assign w_data    = s.rxw[DW-1:0];

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		next_s          = s;
		next_s.scl_q    = scl_f;
		next_s.sda_q    = sda_f;
		next_s.wvalid   = 1'b0;
		next_s.load_strobe_n_q   = load_strobe_n_f;
		next_s.gain     = gain_f; // [RL10]
		next_s.sda_oe_n = !s.sda_low; // [RL2]

		// Two-wire slave; a stop drops any partial word
		if (bus_start) begin
			next_s.st      = QDPC_ADDR;
			next_s.bitcnt  = '0;
			next_s.bytecnt = '0;
			next_s.sda_low = 1'b0;
		end else if (bus_stop) begin
			next_s.st      = QDPC_IDLE;
			next_s.sda_low = 1'b0;
		end else begin
			case (s.st)
				QDPC_ADDR, QDPC_RX: begin
					if (scl_rise) begin
						next_s.sh     = {s.sh[6:0], sda_f}; // [RL1]
						next_s.bitcnt = s.bitcnt + 1'b1;
					end else if (scl_fall && s.bitcnt == qdpc_pkg::BYTE_BITS) begin
						if (s.st == QDPC_ADDR) begin
							if (s.sh[7:1] == slave_addr) begin
								next_s.sda_low = 1'b1; // [RL2]
								next_s.rw      = s.sh[0];
								next_s.txw     = '0;
								next_s.txw[DW-1:0] = s.dac[s.rd_ch];
								next_s.txw[qdpc_pkg::WORD_CH_LSB +: CHW] = s.rd_ch;
								next_s.st      = QDPC_ACK;
							end else begin
								next_s.st = QDPC_IDLE;
							end
						end else begin
							next_s.rxw     = {s.rxw[15:0], s.sh}; // [RL1]
							next_s.sda_low = 1'b1;
							next_s.st      = QDPC_ACK;
							// Third byte closes the word
							if (s.bytecnt == qdpc_pkg::LAST_BYTE) begin
								next_s.wvalid  = 1'b1; // [RL11]
								next_s.bytecnt = '0;
							end else begin
								next_s.bytecnt = s.bytecnt + 1'b1;
							end
						end
					end
				end
				QDPC_ACK: begin
					if (scl_fall && s.rw) begin
						next_s.sda_low = !s.txw[23];
						next_s.txw     = {s.txw[22:0], 1'b0};
						next_s.bitcnt  = 4'h1;
						next_s.st      = QDPC_TX;
					end else if (scl_fall) begin
						next_s.sda_low = 1'b0;
						next_s.bitcnt  = '0;
						next_s.st      = QDPC_RX;
					end
				end
				QDPC_TX: begin
					if (scl_fall && s.bitcnt == qdpc_pkg::BYTE_BITS) begin
						next_s.sda_low = 1'b0;
						next_s.st      = QDPC_MACK;
					end else if (scl_fall) begin
						next_s.sda_low = !s.txw[23]; // [RL2]
						next_s.txw     = {s.txw[22:0], 1'b0};
						next_s.bitcnt  = s.bitcnt + 1'b1;
					end
				end
				QDPC_MACK: begin
					// Master's not-acknowledge ends the read
					if (scl_rise && sda_f) begin
						next_s.st = QDPC_IDLE;
					end else if (scl_fall) begin
						next_s.sda_low = !s.txw[23];
						next_s.txw     = {s.txw[22:0], 1'b0};
						next_s.bitcnt  = 4'h1;
						next_s.st      = QDPC_TX;
					end
				end
				default: begin
					next_s.st = QDPC_IDLE;
				end
			endcase
		end

		// APB: answer in the cycle after setup, zero wait states
		next_s.pready  = apb_setup;
		next_s.pslverr = 1'b0;
		next_s.prdata  = '0;
		if (apb_setup) begin
			if (PADDR == qdpc_pkg::OFS_CTRL) begin
				next_s.prdata[4:0] = s.addr_high;
			end else if (PADDR == qdpc_pkg::OFS_STATUS) begin
				next_s.prdata[NCH+4:0] = {s.st != QDPC_IDLE, !rpin_f, reset_level_select_f, s.gain,
				                          s.init_done, s.pend};
			end else if (in_dac) begin
				next_s.prdata[DW-1:0] = s.dac[a_idx];
			end else if (in_inreg) begin
				next_s.prdata[DW-1:0] = s.inreg[a_idx];
			end else begin
				next_s.pslverr = 1'b1;
			end
		end
		if (apb_wr && PADDR == qdpc_pkg::OFS_CTRL) begin
			next_s.addr_high = PWDATA[4:0];
		end

		// Data registers; reset pin wins over strobe and writes
		if (!rpin_f) begin
			for (int i = 0; i < NCH; i++) begin
				next_s.inreg[i] = qdpc_pkg::rst_code(reset_level_select_f); // [RL6]
				next_s.dac[i]   = qdpc_pkg::rst_code(reset_level_select_f); // [RL6]
			end
			next_s.pend = '0; // [RL7]
		end else if (!s.init_done) begin
			// First cycle out of reset: strap value, then hold
			for (int i = 0; i < NCH; i++) begin
				next_s.inreg[i] = qdpc_pkg::rst_code(reset_level_select_f); // [RL9]
				next_s.dac[i]   = qdpc_pkg::rst_code(reset_level_select_f); // [RL9]
			end
			next_s.pend      = '0; // [RL14]
			next_s.init_done = 1'b1; // [RL8]
		end else begin
			if (load_strobe_n_fall || soft_load) begin
				for (int i = 0; i < NCH; i++) begin
					if (s.pend[i]) begin
						next_s.dac[i] = s.inreg[i]; // [RL3]
					end
				end
				next_s.pend = '0;
			end
			// A word landing with a software load keeps its own pending bit; with a strobe fall it goes straight to its DAC
			if (s.wvalid) begin
				next_s.inreg[w_ch] = w_data;
				next_s.rd_ch       = w_ch;
				if (!load_strobe_n_f) begin
					next_s.dac[w_ch]  = w_data; // [RL4]
					next_s.pend[w_ch] = 1'b0;
				end else begin
					next_s.pend[w_ch] = 1'b1; // [RL4]
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			s           <= '0;
			s.st        <= QDPC_IDLE;
			s.scl_q     <= 1'b1;
			s.sda_q     <= 1'b1;
			s.load_strobe_n_q    <= 1'b1;
			s.sda_oe_n  <= 1'b1;
			s.addr_high <= qdpc_pkg::ADDR_HIGH_RST;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register, SDA_OUT tied low
	assign PRDATA    = s.prdata;
	assign PREADY    = s.pready;
	assign PSLVERR   = s.pslverr;
	assign SDA_OUT   = 1'b0;
	assign SDA_OE_N  = s.sda_oe_n;
	assign DAC_CODE  = s.dac;
	assign GAIN_SPAN = s.gain;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);

	a_reset_loads: assert property ( // [RL6]
		!rpin_f |=> (s.dac[0] == qdpc_pkg::rst_code($past(reset_level_select_f)) && s.pend == '0
		             && s.inreg[NCH-1] == s.dac[NCH-1]))
		else $error("reset pin did not load the reset code");

	a_strobe_blocked: assert property ( // [RL7]
		(!rpin_f && load_strobe_n_fall) |=> (s.pend == '0 && s.dac == s.inreg))
		else $error("load strobe acted during reset");

	a_sync_update: assert property ( // [RL4]
		(rpin_f && s.init_done && s.wvalid && !load_strobe_n_f) |=> (s.dac[$past(w_ch)] == $past(w_data)))
		else $error("word with strobe low did not update its DAC");

	a_deferred_hold: assert property ( // [RL3]
		(rpin_f && s.init_done && s.wvalid && load_strobe_n_f && !load_strobe_n_fall && !soft_load)
		|=> (s.pend[$past(w_ch)] && $stable(s.dac)))
		else $error("word with strobe high changed a DAC");

	a_load_all: assert property ( // [RL3]
		(rpin_f && s.init_done && load_strobe_n_fall && !s.wvalid && s.pend == '1)
		|=> (s.dac == $past(s.inreg) && s.pend == '0))
		else $error("strobe did not move all pending words");

	a_power_up: assert property ( // [RL9]
		$rose(s.init_done) |-> (s.dac[NCH-1] == qdpc_pkg::rst_code($past(reset_level_select_f))
		                        && s.pend == '0 && $past(rpin_f)))
		else $error("power-up value wrong or set during reset");

	a_gain_span: assert property ( // [RL10]
		$changed(gain_f) |=> (GAIN_SPAN == $past(gain_f)) ##1 (GAIN_SPAN == $past(gain_f)))
		else $error("span does not follow the gain strap");

	a_ack_match: assert property ( // [RL2]
		(s.st == QDPC_ADDR && scl_fall && !bus_stop && s.bitcnt == qdpc_pkg::BYTE_BITS
		 && s.sh[7:1] == slave_addr) |=> (s.sda_low ##1 !SDA_OE_N))
		else $error("address match not acknowledged");

	a_word_close: assert property ( // [RL11]
		s.wvalid |-> (s.bytecnt == '0 && s.st == QDPC_ACK && !s.rw))
		else $error("word closed outside third byte");

	a_apb_answer: assert property (
		apb_setup |=> (PREADY ##1 !PREADY))
		else $error("APB answer not exactly one cycle after setup");

endmodule

// *** sim/qdpc_i2c_master.sv ***
// Two-wire bus master model that feeds 24-bit words to the DAC pin block.
// Assumes the bench resolves SDA with a pull-up; SCL idles high outside frames.
`timescale 1ns/1ps
module qdpc_i2c_master #(
	parameter int Q = 40
) (
	// Clock
	input  wire logic clk,
	// Bus lines
	input  wire logic sda_in,
	output logic      scl,
	output logic      sda_low
);
	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	// Both lines released at start
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic gap(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One byte MSB first, then a released bit for the acknowledge
	task automatic put_byte(input logic [7:0] b, input logic spike, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_low <= ~b[i]; // Pull low or release, never drive high
			gap(Q);
			scl <= 1'b1;
			gap(Q);
			// 40 ns dip in the high phase, must not count as a clock
			if (spike) begin
				scl <= 1'b0;
				gap(10);
				scl <= 1'b1;
			end
			gap(Q);
			scl <= 1'b0;
			gap(Q);
		end
		sda_low <= 1'b0;
		gap(Q);
		scl <= 1'b1;
		gap(Q);
		ack = ~sda_in;
		gap(Q);
		scl <= 1'b0;
		gap(Q);
	endtask

	// Start, address with write bit, three data bytes, stop
	task automatic write_word(input logic [6:0] a, input logic [23:0] w,
		input logic spike, output logic ok);
		logic k0, k1, k2, k3;
		sda_low <= 1'b1;
		gap(Q);
		scl <= 1'b0;
		gap(Q);
		put_byte({a, 1'b0}, 1'b0, k0);
		put_byte(w[23:16], spike, k1);
		put_byte(w[15:8], 1'b0, k2);
		put_byte(w[7:0], 1'b0, k3);
		sda_low <= 1'b1;
		gap(Q);
		scl <= 1'b1;
		gap(Q);
		sda_low <= 1'b0;
		gap(2 * Q);
		ok = k0 & k1 & k2 & k3;
	endtask

	// Start, address with read bit, 24 bits in, last byte refused
	task automatic read_word(input logic [6:0] a, output logic [23:0] w, output logic ok);
		sda_low <= 1'b1;
		gap(Q);
		scl <= 1'b0;
		gap(Q);
		put_byte({a, 1'b1}, 1'b0, ok);
		for (int i = 23; i >= 0; i--) begin
			gap(Q);
			scl <= 1'b1;
			gap(Q);
			w[i] = sda_in;
			gap(Q);
			scl <= 1'b0;
			gap(Q);
			// Acknowledge each byte; a released line after the last ends the read
			if (i % 8 == 0) begin
				sda_low <= (i != 0);
				gap(Q);
				scl <= 1'b1;
				gap(2 * Q);
				scl <= 1'b0;
				gap(Q);
				sda_low <= 1'b0;
			end
		end
		gap(Q);
		sda_low <= 1'b1;
		gap(Q);
		scl <= 1'b1;
		gap(Q);
		sda_low <= 1'b0;
		gap(2 * Q);
	endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the quad DAC pin control block.
// Assumes the APB port and the bus master model share the 250 MHz clock.
`timescale 1ns/1ps
module tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic             SYS_CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [11:0]      PADDR;
	logic [31:0]      PWDATA, PRDATA, rd;
	logic             SDA_OUT, SDA_OE_N, scl, sda_low, err, ok;
	logic             LOAD_STROBE_N, DAC_RESET_N, RESET_LEVEL_SELECT, GAIN_SEL;
	logic             ADDR_STRAP_BIT1, ADDR_STRAP_BIT0, GAIN_SPAN;
	logic [3:0][15:0] DAC_CODE;
	logic [23:0]      rword;
	int               fails = 0, compares = 0, cyc = 0;
	localparam logic [15:0] MID = qdpc_pkg::CODE_MID;
	localparam logic [6:0]  ADR = {qdpc_pkg::ADDR_HIGH_RST, 2'h1};
	// Open drain line with pull-up
	wire sda = !(sda_low || !SDA_OE_N);

	qdpc_top u_qdpc_top (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_IN(scl),
		.SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
		.LOAD_STROBE_N(LOAD_STROBE_N), .DAC_RESET_N(DAC_RESET_N),
		.RESET_LEVEL_SELECT(RESET_LEVEL_SELECT), .GAIN_SEL(GAIN_SEL),
		.ADDR_STRAP_BIT1(ADDR_STRAP_BIT1), .ADDR_STRAP_BIT0(ADDR_STRAP_BIT0),
		.DAC_CODE(DAC_CODE), .GAIN_SPAN(GAIN_SPAN));
	qdpc_i2c_master u_qdpc_i2c_master (.clk(SYS_CLK), .sda_in(sda), .scl(scl),
		.sda_low(sda_low));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One APB transfer, held until PREADY is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		// Only the bench timeout ends a wait that never sees PREADY
		do begin
			@(posedge SYS_CLK);
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge SYS_CLK);
	endtask

	task automatic wr(input logic [6:0] a, input logic [1:0] ch, input logic [15:0] v,
		input logic sp);
		u_qdpc_i2c_master.write_word(a, {6'h00, ch, v}, sp, ok);
	endtask

	// Strobe pulse long enough to pass the pin synchroniser
	task automatic pulse_load;
		LOAD_STROBE_N <= 1'b0;
		repeat (4) @(posedge SYS_CLK);
		LOAD_STROBE_N <= 1'b1;
		repeat (6) @(posedge SYS_CLK);
	endtask

	task automatic wrap_up;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, timeout and tests
	// ------------------------------------------------------------
	initial SYS_CLK = 1'b0;
	always #2 SYS_CLK = ~SYS_CLK;

	// About nine words at six thousand cycles each, with margin
	always @(posedge SYS_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			fails++;
			wrap_up;
		end
	end

	initial begin
		RST_B = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h000;
		PWDATA = 32'h0000_0000;
		LOAD_STROBE_N = 1'b1;
		DAC_RESET_N = 1'b0;
		RESET_LEVEL_SELECT = 1'b1;
		GAIN_SEL = 1'b0;
		ADDR_STRAP_BIT1 = 1'b0;
		ADDR_STRAP_BIT0 = 1'b1;
		repeat (4) @(posedge SYS_CLK);
		RST_B <= 1'b1;
		repeat (10) @(posedge SYS_CLK);
		// Reset pin held from power-up: midscale, not initialised
		apb(1'b0, qdpc_pkg::OFS_STATUS, 32'h0);
		chk(64'({rd[7], rd[4]}), 64'h2);
		chk(DAC_CODE, {4{MID}});
		DAC_RESET_N <= 1'b1;
		repeat (10) @(posedge SYS_CLK);
		apb(1'b0, qdpc_pkg::OFS_STATUS, 32'h0);
		chk(64'({rd[7], rd[4]}), 64'h1);
		chk(64'({SDA_OE_N, SDA_OUT}), 64'h2);
		GAIN_SEL <= 1'b1;
		repeat (6) @(posedge SYS_CLK);
		chk(64'(GAIN_SPAN), 64'h1);
		GAIN_SEL <= 1'b0;
		repeat (6) @(posedge SYS_CLK);
		chk(64'(GAIN_SPAN), 64'h0);
		// Four buffered words, spike on the first
		wr(ADR, 2'h1, 16'hFFFF, 1'b1);
		chk(64'(ok), 64'h1);
		wr(ADR, 2'h0, 16'h0000, 1'b0);
		wr(ADR, 2'h3, 16'h5A5A, 1'b0);
		wr(ADR, 2'h2, 16'hC3C3, 1'b0);
		chk(DAC_CODE, {4{MID}});
		apb(1'b0, qdpc_pkg::OFS_INREG + 12'h004, 32'h0);
		chk(64'(rd), 64'h0000_FFFF);
		pulse_load;
		chk(DAC_CODE, {16'h5A5A, 16'hC3C3, 16'hFFFF, 16'h0000});
		// Straps move the address; the old one is no longer answered
		ADDR_STRAP_BIT1 <= 1'b1;
		ADDR_STRAP_BIT0 <= 1'b0;
		repeat (10) @(posedge SYS_CLK);
		wr(ADR, 2'h2, 16'h0BAD, 1'b0);
		chk(64'(ok), 64'h0);
		// Strobe tied low: word goes straight to its DAC
		LOAD_STROBE_N <= 1'b0;
		wr({qdpc_pkg::ADDR_HIGH_RST, 2'h2}, 2'h2, 16'h1234, 1'b0);
		chk(64'(ok), 64'h1);
		chk(DAC_CODE, {16'h5A5A, 16'h1234, 16'hFFFF, 16'h0000});
		LOAD_STROBE_N <= 1'b1;
		// Reset pin with a pending word and a strobe while low
		RESET_LEVEL_SELECT <= 1'b0;
		wr({qdpc_pkg::ADDR_HIGH_RST, 2'h2}, 2'h3, 16'hABCD, 1'b0);
		DAC_RESET_N <= 1'b0;
		repeat (6) @(posedge SYS_CLK);
		pulse_load;
		chk(DAC_CODE, 64'h0);
		apb(1'b0, qdpc_pkg::OFS_INREG + 12'h00C, 32'h0);
		chk(64'(rd), 64'h0);
		DAC_RESET_N <= 1'b1;
		repeat (6) @(posedge SYS_CLK);
		pulse_load;
		chk(DAC_CODE, 64'h0);
		// Software load and new upper address in one control write, then read back
		wr({qdpc_pkg::ADDR_HIGH_RST, 2'h2}, 2'h1, 16'h7E81, 1'b0);
		apb(1'b1, qdpc_pkg::OFS_CTRL, 32'h0000_0115);
		chk(DAC_CODE, 64'h0000_0000_7E81_0000);
		u_qdpc_i2c_master.read_word({5'h15, 2'h2}, rword, ok);
		chk(64'(ok), 64'h1);
		chk(64'(rword), 64'h0001_7E81);
		apb(1'b0, qdpc_pkg::OFS_CTRL, 32'h0);
		chk(64'(rd), 64'h15);
		// Unmapped address answers with an error
		apb(1'b0, 12'h100, 32'h0);
		chk(64'(err), 64'h1);
		wrap_up;
	end
endmodule
